// File: common/ftssp_pkg.sv
// Shared sizes, reset values and operation codes of the flow-through port.
package ftssp_pkg;

   // Array organisation: 2M words of 32 data bits.
   localparam int ADDR_W    = 21;
   localparam int DATA_W    = 32;
   localparam int MEM_WORDS = 2 ** ADDR_W;

   // Check bits: six Hamming parity bits plus one overall parity bit.
   localparam int PAR_W = 6;
   localparam int ECC_W = DATA_W + PAR_W + 1;

   // Burst counter: two bits, four words a burst.
   localparam int BURST_W = 2;
   localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
   localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;

   // Address reset value and scrub pointer step.
   localparam logic [ADDR_W-1:0] ADDR_RESET = 21'h000000;
   localparam logic [ADDR_W-1:0] SCRUB_STEP = 21'h000001;

   // Burst order strap encoding.
   localparam logic ORDER_LINEAR      = 1'b0;
   localparam logic ORDER_INTERLEAVED = 1'b1;

   // Operation held in the registered stage.
   typedef enum logic [3:0]
   {
      OP_IDLE  = 4'h1,
      OP_READ  = 4'h2,
      OP_WRITE = 4'h4,
      OP_FLUSH = 4'h8
   } ftssp_op_e;

endpackage

// File: logic/ftssp_secded.sv
// Single-error-correct, double-error-detect encoder and decoder.
module ftssp_secded
(
   // Encoder side.
   input  wire logic [ftssp_pkg::DATA_W-1:0] data_i,
   output logic      [ftssp_pkg::ECC_W-1:0]  code_o,
   // Decoder side.
   input  wire logic [ftssp_pkg::ECC_W-1:0]  code_i,
   output logic      [ftssp_pkg::DATA_W-1:0] data_o,
   output logic      [ftssp_pkg::ECC_W-1:0]  fixed_o,
   output logic                              single_o,
   output logic                              double_o
);

   logic [ftssp_pkg::ECC_W-1:0] enc_cw;
   logic [ftssp_pkg::ECC_W-1:0] dec_fix;
   logic [ftssp_pkg::PAR_W-1:0] dec_syn;
   logic                        dec_over;

   // Codeword position of data bit k: the k-th position that is not a
   // power of two. Bit 0 of the codeword holds the overall parity.
   function automatic int data_pos(input int k);
      int n;
      int pos;
      n = 0;
      pos = 0;
      for (int p = 1; p < ftssp_pkg::ECC_W; p++)
      begin
         if ((p & (p - 1)) != 0)
         begin
            if (n == k)
            begin
               pos = p;
            end
            n++;
         end
      end
      return pos;
   endfunction

   // Encoder: scatter data, fill parity positions, then overall parity.
   always_comb
   begin
      enc_cw = '0;
      for (int k = 0; k < ftssp_pkg::DATA_W; k++)
      begin
         enc_cw[data_pos(k)] = data_i[k];
      end
      for (int j = 0; j < ftssp_pkg::PAR_W; j++)
      begin
         for (int p = 1; p < ftssp_pkg::ECC_W; p++)
         begin
            if (((p >> j) & 1) == 1)
            begin
               enc_cw[1 << j] = enc_cw[1 << j] ^ enc_cw[p];
            end
         end
      end
      enc_cw[0] = ^enc_cw[ftssp_pkg::ECC_W-1:1];
      code_o = enc_cw;
   end

   // Decoder: a nonzero syndrome with even overall parity is a double
   // error; a syndrome past the last position cannot be a single one.
   always_comb
   begin
      dec_syn = '0;
      for (int j = 0; j < ftssp_pkg::PAR_W; j++)
      begin
         for (int p = 1; p < ftssp_pkg::ECC_W; p++)
         begin
            if (((p >> j) & 1) == 1)
            begin
               dec_syn[j] = dec_syn[j] ^ code_i[p];
            end
         end
      end
      dec_over = ^code_i;
      dec_fix = code_i;
      single_o = 1'b0;
      double_o = 1'b0;
      if (dec_over)
      begin
         if (int'(dec_syn) < ftssp_pkg::ECC_W)
         begin
            dec_fix[dec_syn] = ~code_i[dec_syn];
            single_o = 1'b1;
         end
         else
         begin
            double_o = 1'b1;
         end
      end
      else if (dec_syn != '0)
      begin
         double_o = 1'b1;
      end
      fixed_o = dec_fix;
      for (int k = 0; k < ftssp_pkg::DATA_W; k++)
      begin
         data_o[k] = dec_fix[data_pos(k)];
      end
   end

endmodule

// File: logic/ftssp_port.sv
// Flow-through synchronous static memory port with protected array.

module ftssp_port
#(
   parameter int ADDR_W = ftssp_pkg::ADDR_W,
   parameter int DATA_W = ftssp_pkg::DATA_W
)
(
   // Clock and reset.
   input  wire logic              core_clk_i,
   input  wire logic              rstn_i,
   // Synchronous control.
   input  wire logic              clock_gate_n_i,
   input  wire logic              select_a_n_i,
   input  wire logic              select_b_i,
   input  wire logic              select_c_n_i,
   input  wire logic              write_n_i,
   input  wire logic              burst_advance_load_i,
   input  wire logic              pipeline_flush_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   // Static strap and asynchronous output enable.
   input  wire logic              burst_order_i,
   input  wire logic              output_enable_n_i,
   // Data pins, split into input, output and output enable.
   input  wire logic [DATA_W-1:0] dq_i,
   output logic      [DATA_W-1:0] dq_o,
   output logic                   dq_oe_o,
   // Read data integrity.
   output logic                   ecc_uncorrectable_o
);

   // Width of the burst step counter.
   localparam int BW = ftssp_pkg::BURST_W;

   // Registered access stage.
   ftssp_pkg::ftssp_op_e op_q;
   ftssp_pkg::ftssp_op_e op_d;
   logic [ADDR_W-1:0]    base_q;
   logic [ADDR_W-1:0]    base_d;
   logic [BW-1:0]        start_q;
   logic [BW-1:0]        start_d;
   logic [BW-1:0]        count_q;
   logic [BW-1:0]        count_d;
   logic                 order_q;
   logic                 order_d;
   logic                 dsel_q;
   logic                 dsel_d;

   // Scrubber state.
   logic [ADDR_W-1:0]    scrub_ptr_q;
   logic [ADDR_W-1:0]    scrub_ptr_d;

   // Array and its access nets.
   logic [ftssp_pkg::ECC_W-1:0] mem_q [ftssp_pkg::MEM_WORDS];
   logic [ftssp_pkg::ECC_W-1:0] host_code;
   logic [ftssp_pkg::ECC_W-1:0] wr_code;
   logic [ftssp_pkg::ECC_W-1:0] scrub_code;
   logic [ftssp_pkg::ECC_W-1:0] scrub_fixed;
   logic [DATA_W-1:0]           host_data;
   logic                        host_double;
   logic                        scrub_single;
   logic [BW-1:0]               burst_low;
   logic [ADDR_W-1:0]           word_addr;
   logic                        qualified;
   logic                        selected;
   logic                        commit;
   logic                        scrub_fix;
   logic                        mem_we;
   logic [ADDR_W-1:0]           mem_waddr;
   logic [ftssp_pkg::ECC_W-1:0] mem_wdata;

   // Clock edges count only with the gate low; otherwise the access stage holds, though the scrubber runs.
   // Reset is not gated, so a reset edge acts even with the gate high.
   assign qualified = ~clock_gate_n_i;

   // All three selects must agree on the same sampled edge.
   // One select out of place is enough to deselect the port.
   assign selected = ~select_a_n_i & select_b_i & ~select_c_n_i;

   // Word inside the burst, from the start bits and the step count.
   // The count wraps after four steps back to the start word.
   always_comb
   begin
      if (order_q == ftssp_pkg::ORDER_LINEAR)
      begin
         burst_low = start_q + count_q;
      end
      else
      begin
         burst_low = start_q ^ count_q;
      end
   end

   // The upper bits of a burst never change; only the low pair steps.
   assign word_addr = {base_q[ADDR_W-1:BW], burst_low};

   // Next-state logic of the access stage. Advance steps the burst only
   // while one is running, so an advance straight out of deselect is a
   // dead cycle with drivers off instead of a read of a stale address.
   // Selects count on advance edges too, so a deselect ends a burst.
   always_comb
   begin
      op_d = op_q;
      base_d = base_q;
      start_d = start_q;
      count_d = count_q;
      order_d = order_q;
      dsel_d = dsel_q;
      if (!rstn_i)
      begin
         op_d = ftssp_pkg::OP_IDLE;
         base_d = ftssp_pkg::ADDR_RESET;
         start_d = ftssp_pkg::BURST_FIRST;
         count_d = ftssp_pkg::BURST_FIRST;
         order_d = burst_order_i;
         dsel_d = 1'b1;
      end
      else if (qualified)
      begin
         if (!selected)
         begin
            op_d = ftssp_pkg::OP_IDLE;
            dsel_d = 1'b1;
         end
         else if (!burst_advance_load_i)
         begin
            base_d = addr_i;
            start_d = addr_i[BW-1:0];
            count_d = ftssp_pkg::BURST_FIRST;
            dsel_d = 1'b0;
            if (write_n_i)
            begin
               op_d = ftssp_pkg::OP_READ;
            end
            else if (pipeline_flush_i)
            begin
               op_d = ftssp_pkg::OP_FLUSH;
            end
            else
            begin
               op_d = ftssp_pkg::OP_WRITE;
            end
         end
         else if (dsel_q)
         begin
            op_d = ftssp_pkg::OP_IDLE;
         end
         else
         begin
            count_d = count_q + ftssp_pkg::BURST_STEP;
         end
      end
   end

   // Access stage registers.
   // Reset is folded into the next-state logic, so none is needed here.
   always_ff @(posedge core_clk_i)
   begin
      op_q <= op_d;
      base_q <= base_d;
      start_q <= start_d;
      count_q <= count_d;
      order_q <= order_d;
      dsel_q <= dsel_d;
   end

   // A write's data is taken on the qualified edge that closes its data
   // phase; a dummy write in flush mode passes that edge storing nothing.
   // With the gate high the data phase stretches, so the host must keep
   // its write data on the pins until the next qualified edge.
   assign commit = qualified && rstn_i
                   && (op_q == ftssp_pkg::OP_WRITE);

   // Scrubbing writes back a corrected word only when the host is not
   // writing; the host always wins, so the scrubber costs it nothing.
   assign scrub_fix = rstn_i && !commit && scrub_single;

   // Scrub pointer walks the array, pausing while it yields to the host.
   // A full pass takes one clock per word, so a weak word may wait that
   // long for repair; host reads are corrected on the fly meanwhile.
   always_comb
   begin
      scrub_ptr_d = scrub_ptr_q;
      if (!rstn_i)
      begin
         scrub_ptr_d = ftssp_pkg::ADDR_RESET;
      end
      else if (!commit)
      begin
         scrub_ptr_d = scrub_ptr_q + ftssp_pkg::SCRUB_STEP;
      end
   end

   // Scrub pointer register.
   always_ff @(posedge core_clk_i)
   begin
      scrub_ptr_q <= scrub_ptr_d;
   end

   // Array write select: host data first, then scrub repairs. One shared
   // write port keeps the array simple, which is why the scrubber stands
   // aside whenever the host commits.
   always_comb
   begin
      mem_we = 1'b0;
      mem_waddr = word_addr;
      mem_wdata = wr_code;
      if (commit)
      begin
         mem_we = 1'b1;
      end
      else if (scrub_fix)
      begin
         mem_we = 1'b1;
         mem_waddr = scrub_ptr_q;
         mem_wdata = scrub_fixed;
      end
   end

   // Array register. The array is not reset; its contents are undefined
   // until first written, and a reset in mid-run leaves them intact.
   always_ff @(posedge core_clk_i)
   begin
      if (mem_we)
      begin
         mem_q[mem_waddr] <= mem_wdata;
      end
   end

   // Two read ports: one follows the registered host address, one the
   // scrubber. The host port is unclocked so data flows through.
   // Both reads are unclocked, so the array needs two read ports.
   assign host_code = mem_q[word_addr];
   assign scrub_code = mem_q[scrub_ptr_q];

   // Host path: encode incoming write data, correct outgoing read data.
   // The encoder runs on whatever the pins carry; only a commit stores it.
   ftssp_secded u_host_ecc
   (
      .data_i   (dq_i),
      .code_o   (wr_code),
      .code_i   (host_code),
      .data_o   (host_data),
      .fixed_o  (),
      .single_o (),
      .double_o (host_double)
   );

   // Scrub path: only the decoder is used; double errors are left alone
   // because no correct value exists to write back.
   ftssp_secded u_scrub_ecc
   (
      .data_i   ('0),
      .code_o   (),
      .code_i   (scrub_code),
      .data_o   (),
      .fixed_o  (scrub_fixed),
      .single_o (scrub_single),
      .double_o ()
   );

   // Data is corrected before it reaches the pins, within the cycle.
   // The cost is a full array read and decode inside one clock; a
   // registered output would add a cycle of read latency.
   assign dq_o = host_data;

   // Drivers turn on only in a read cycle with the enable low; writes,
   // flushes, deselect and dead advance cycles all hold the stage idle
   // or non-read, so the enable is masked there whatever its level.
   // The enable is asynchronous and acts within the cycle, without an edge.
   assign dq_oe_o = (op_q == ftssp_pkg::OP_READ)
                    && !output_enable_n_i;

   // Corrupt read data is flagged only in a read cycle, whatever the output enable level.
   // The flag is unclocked and stands exactly as long as the read word.
   assign ecc_uncorrectable_o = (op_q == ftssp_pkg::OP_READ)
                                && host_double;

endmodule

// File: tb/ftssp_port_asserts.sv
// Concurrent checks on the pins of the flow-through memory port.
module ftssp_port_asserts
#(
   parameter int ADDR_W = 21,
   parameter int DATA_W = 32
)
(
   // Clock and reset.
   input  wire logic              core_clk_i,
   input  wire logic              rstn_i,
   // Synchronous control.
   input  wire logic              clock_gate_n_i,
   input  wire logic              select_a_n_i,
   input  wire logic              select_b_i,
   input  wire logic              select_c_n_i,
   input  wire logic              write_n_i,
   input  wire logic              burst_advance_load_i,
   input  wire logic              pipeline_flush_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   // Strap, output enable and data.
   input  wire logic              burst_order_i,
   input  wire logic              output_enable_n_i,
   input  wire logic [DATA_W-1:0] dq_i,
   input  wire logic [DATA_W-1:0] dq_o,
   input  wire logic              dq_oe_o,
   input  wire logic              ecc_uncorrectable_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic sel;
   logic qual;
   logic ld;

   // Qualified edge, full select and address load decoded once.
   assign sel  = !select_a_n_i && select_b_i && !select_c_n_i;
   assign qual = rstn_i && !clock_gate_n_i;
   assign ld   = qual && sel && !burst_advance_load_i;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);

   gate_hold_a:
      assert property (rstn_i && clock_gate_n_i |=> $changed(output_enable_n_i)
         || $stable(dq_oe_o) && (!dq_oe_o || $stable(dq_o)))
      else $error("Output moved while the clock gate was high.");
   desel_off_a:
      assert property (qual && !sel |=> !dq_oe_o)
      else $error("Data driven after a deselect edge.");
   write_hiz_a:
      assert property (ld && !write_n_i |=> !dq_oe_o)
      else $error("Data driven during a write data phase.");
   read_drive_a:
      assert property (ld && write_n_i |=> dq_oe_o == !output_enable_n_i)
      else $error("Read cycle drive does not follow output enable.");
   oe_mask_a:
      assert property (output_enable_n_i |-> !dq_oe_o)
      else $error("Data driven with output enable high.");
   dead_cycle_a:
      assert property (qual && !sel ##1 qual && sel && burst_advance_load_i
         |=> !dq_oe_o)
      else $error("Advance right after deselect drove data.");
   same_word_a:
      assert property (ld && !write_n_i && !pipeline_flush_i
         ##1 ld && write_n_i && $stable(addr_i) |=> dq_o == $past(dq_i))
      else $error("Read right after write missed the new word.");
   flush_drop_a:
      assert property (ld && !write_n_i && pipeline_flush_i
         ##1 ld && write_n_i && $stable(addr_i) |=> $stable(dq_o))
      else $error("Dummy write changed the stored word.");
   flag_quiet_a:
      assert property (qual && !sel |=> !ecc_uncorrectable_o)
      else $error("Error flag raised outside a read cycle.");
endmodule

bind ftssp_port ftssp_port_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk
(
   .core_clk_i(core_clk_i), .rstn_i(rstn_i), .clock_gate_n_i(clock_gate_n_i),
   .select_a_n_i(select_a_n_i), .select_b_i(select_b_i),
   .select_c_n_i(select_c_n_i), .write_n_i(write_n_i),
   .burst_advance_load_i(burst_advance_load_i),
   .pipeline_flush_i(pipeline_flush_i), .addr_i(addr_i),
   .burst_order_i(burst_order_i), .output_enable_n_i(output_enable_n_i),
   .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
   .ecc_uncorrectable_o(ecc_uncorrectable_o)
);

// File: tb/ftssp_host_bus.sv
// Host end of the shared data wire of the memory port.
module ftssp_host_bus
(
   // Clock.
   input  wire logic        core_clk_i,
   // Host and device drivers.
   input  wire logic        host_oe_i,
   input  wire logic [31:0] host_d_i,
   input  wire logic        dev_oe_i,
   input  wire logic [31:0] dev_d_i,
   // Resolved wire level.
   output logic      [31:0] bus_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [31:0] last_q;

   // Floating wire toggles every cycle so stale data never looks valid.
   always_ff @(posedge core_clk_i)
      last_q <= bus_o;

   // Host data goes out whenever the host enables it, and wins over the device if both drive.
   always_comb
   begin
      if (host_oe_i)
         bus_o = host_d_i;
      else if (dev_oe_i)
         bus_o = dev_d_i;
      else
         bus_o = ~last_q;
   end
endmodule

// File: tb/ftssp_port_tb.sv
// Self-checking bench for the flow-through memory port.
module ftssp_port_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [2:0] SEL = 3'b010;
   logic        core_clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        gate_n = 1'b0;
   logic [2:0]  sel = 3'b111;
   logic        adv = 1'b0;
   logic        wn = 1'b1;
   logic        fl = 1'b0;
   logic [20:0] addr = 21'h000000;
   logic        order = 1'b0;
   logic        oe_n = 1'b0;
   logic        host_oe = 1'b0;
   logic [31:0] host_d = 32'h0;
   logic        wr_pend = 1'b0;
   logic [31:0] wr_data = 32'h0;
   logic [31:0] dq_in;
   logic [31:0] dq_out;
   logic        dq_oe;
   logic        ecc;
   int          n_fail = 0;
   int          tests_run = 0;
   int          cycles = 0;

   always #12.5 core_clk_i = ~core_clk_i;

   ftssp_port uut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .clock_gate_n_i(gate_n), .select_a_n_i(sel[2]), .select_b_i(sel[1]),
      .select_c_n_i(sel[0]), .write_n_i(wn), .burst_advance_load_i(adv),
      .pipeline_flush_i(fl), .addr_i(addr), .burst_order_i(order),
      .output_enable_n_i(oe_n), .dq_i(dq_in), .dq_o(dq_out),
      .dq_oe_o(dq_oe), .ecc_uncorrectable_o(ecc));

   ftssp_host_bus host (.core_clk_i(core_clk_i), .host_oe_i(host_oe),
      .host_d_i(host_d), .dev_oe_i(dq_oe), .dev_d_i(dq_out), .bus_o(dq_in));

   // Compare and count; a mismatch is reported at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Reset latches the burst order strap; the array keeps its words.
   task automatic rst(input logic ord);
      @(negedge core_clk_i);
      rstn_i = 1'b0;
      order = ord;
      repeat (10) @(negedge core_clk_i);
      rstn_i = 1'b1;
   endtask

   // One qualified cycle; write data trails its address by one cycle.
   task automatic op(input logic [2:0] s, input int a, input int w,
                     input int f, input logic [20:0] ad,
                     input logic [31:0] d);
      @(negedge core_clk_i);
      sel = s;
      adv = a[0];
      wn = w[0];
      fl = f[0];
      addr = ad;
      host_oe = wr_pend;
      host_d = wr_data;
      wr_pend = (s == SEL) && (a == 0) && (w == 0);
      wr_data = d;
      @(posedge core_clk_i);
      #1;
   endtask

   task automatic t_wr_rd;
      op(SEL, 0, 0, 0, 21'h000010, 32'h1234abcd);
      op(SEL, 0, 0, 0, 21'h000011, 32'h0badf00d);
      check(32'(dq_oe), 32'h0);
      op(SEL, 0, 1, 0, 21'h000011, 32'h0);
      check(dq_out, 32'h0badf00d);
      check(32'(dq_oe), 32'h1);
      op(SEL, 0, 1, 0, 21'h000010, 32'h0);
      check(dq_out, 32'h1234abcd);
      check(32'(ecc), 32'h0);
   endtask

   task automatic t_gate;
      @(negedge core_clk_i);
      oe_n = 1'b1;
      @(posedge core_clk_i);
      #1;
      check(32'(dq_oe), 32'h0);
      @(negedge core_clk_i);
      oe_n = 1'b0;
      gate_n = 1'b1;
      sel = 3'b111;
      wn = 1'b0;
      addr = 21'h000011;
      repeat (3) @(posedge core_clk_i);
      #1;
      check(dq_out, 32'h1234abcd);
      check(32'(dq_oe), 32'h1);
      @(negedge core_clk_i);
      gate_n = 1'b0;
      op(SEL, 0, 1, 0, 21'h000010, 32'h0);
      check(dq_out, 32'h1234abcd);
   endtask

   task automatic t_desel;
      logic [2:0] bad [6] = '{3'b000, 3'b001, 3'b011, 3'b100, 3'b110, 3'b111};
      for (int k = 0; k < 6; k++)
      begin
         op(SEL, 0, 1, 0, 21'h000010, 32'h0);
         op(bad[k], 0, 1, 0, 21'h000010, 32'h0);
         check(32'(dq_oe), 32'h0);
      end
      op(SEL, 1, 1, 0, 21'h000010, 32'h0);
      check(32'(dq_oe), 32'h0);
      op(SEL, 0, 1, 0, 21'h000011, 32'h0);
      check(dq_out, 32'h0badf00d);
   endtask

   task automatic t_flush;
      op(SEL, 0, 0, 1, 21'h000010, 32'hdeadbeef);
      op(SEL, 0, 1, 0, 21'h000010, 32'h0);
      check(dq_out, 32'h1234abcd);
      repeat (40) op(3'b111, 0, 1, 0, 21'h000000, 32'h0);
      op(SEL, 0, 1, 0, 21'h000011, 32'h0);
      check(dq_out, 32'h0badf00d);
   endtask

   // Advance edges carry a wrong address, which must be ignored.
   task automatic t_burst(input logic ord, input logic [1:0] st);
      logic [1:0] lo;
      rst(ord);
      for (int i = 0; i < 4; i++)
      begin
         lo = ord ? (st ^ i[1:0]) : (st + i[1:0]);
         op(SEL, int'(i != 0), 1, 0,
            (i != 0) ? 21'h1fffff : {19'h1, st}, 32'h0);
         check(dq_out, 32'hc0de0000 + {30'h0, lo});
      end
   endtask

   // Cut a hang short; the run needs well under a thousand cycles.
   always @(posedge core_clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_fail++;
         finish_test();
      end
   end

   // Main sequence.
   initial
   begin
      rst(1'b0);
      for (int k = 0; k < 4; k++)
         op(SEL, 0, 0, 0, 21'(4 + k), 32'hc0de0000 + k);
      op(3'b111, 0, 1, 0, 21'h000000, 32'h0);
      t_wr_rd();
      t_gate();
      t_desel();
      t_flush();
      t_burst(1'b0, 2'h2);
      t_burst(1'b1, 2'h1);
      finish_test();
   end
endmodule
